/* rtl/sfm_cfg.svh */
// constants of the sensor fault monitor logic
`ifndef SFM_CFG_SVH
`define SFM_CFG_SVH

// ==========================================================
// register map, as register index
`define SFM_ADDR_W          8
`define SFM_DATA_W          16
`define SFM_IDX_FAULT_CFG   8'h05
`define SFM_IDX_ALARM       8'h08
`define SFM_FAULT_CFG_RST   16'h0000
`define SFM_ZERO_DATA       16'h0000

// ==========================================================
// fault_and_limit_config fields
`define SFM_CFG_INT_POL     8
`define SFM_CFG_EXT_POL     9
`define SFM_CFG_INT_EN      10
`define SFM_CFG_EXT_EN      11

// ==========================================================
// synchronised comparator vector layout
`define SFM_CMP_W           10
`define SFM_EXT_LSB         0
`define SFM_EXT_W           4
`define SFM_INT_LSB         4
`define SFM_INT_W           5
`define SFM_EXC_BIT         9
`define SFM_ALM_W           9
`define SFM_SYNC_RST        10'h000

`endif

/* rtl/sfm_pkg.sv */
// types of the sensor fault monitor logic
`include "sfm_cfg.svh"

package sfm_pkg;

  typedef struct packed {
    logic [`SFM_CMP_W-1:0] stage1;
    logic [`SFM_CMP_W-1:0] stage2;
  } sfm_sync_t;

  typedef struct packed {
    logic [`SFM_DATA_W-1:0] cfg;
    logic [`SFM_DATA_W-1:0] alarm;
    logic [`SFM_DATA_W-1:0] rd_data;
    logic                   force_on;
    logic                   level_high;
    logic                   thresh_exc;
  } sfm_state_t;

endpackage : sfm_pkg

/* rtl/sfm_sync2.sv */
// two-stage synchroniser for the comparator levels
`timescale 1ns/10ps
`include "sfm_cfg.svh"

module sfm_sync2 (
  input  wire logic                  clk_in,   // system clock
  input  wire logic                  rstn_in,  // sync reset, active low
  input  wire logic [`SFM_CMP_W-1:0] async_in, // raw comparator levels
  output logic      [`SFM_CMP_W-1:0] sync_out  // synchronised levels
);
  import sfm_pkg::*;

  sfm_sync_t sync_reg;
  sfm_sync_t sync_next;

  always_comb begin
    sync_next        = sync_reg;
    sync_next.stage1 = async_in;
    // stage1 is read by stage2 only
    sync_next.stage2 = sync_reg.stage1;
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      sync_reg <= {`SFM_SYNC_RST, `SFM_SYNC_RST};
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg.stage2;

endmodule : sfm_sync2

/* rtl/sfm_group.sv */
// one comparator group: any-high flag and its force gate
`timescale 1ns/10ps

module sfm_group #(
  parameter int W = 4
) (
  input  wire logic [W-1:0] cmp_in,    // synchronised comparators
  input  wire logic         enable_in, // force enable of the group
  output logic              flag_out,  // any comparator high
  output logic              active_out // flag allowed to force
);

  assign flag_out   = |cmp_in;
  assign active_out = flag_out & enable_in;

endmodule : sfm_group

/* rtl/sfm_monitor.sv */
// sensor fault monitor logic: comparator groups, alarm status, output forcing
// ==========================================================
`timescale 1ns/10ps
`include "sfm_cfg.svh"

module sfm_monitor (
  input  wire logic                   CLK_IN,                        // 10 MHz clock
  input  wire logic                   RSTN_IN,                       // sync reset, active low
  input  wire logic                   POS_INPUT_HIGH_COMPARATOR_IN,  // positive input too high
  input  wire logic                   POS_INPUT_LOW_COMPARATOR_IN,   // positive input too low
  input  wire logic                   NEG_INPUT_HIGH_COMPARATOR_IN,  // negative input too high
  input  wire logic                   NEG_INPUT_LOW_COMPARATOR_IN,   // negative input too low
  input  wire logic                   AMP1_SAT_HIGH_IN,              // amplifier 1 at supply
  input  wire logic                   AMP1_SAT_LOW_IN,               // amplifier 1 at ground
  input  wire logic                   AMP2_SAT_HIGH_IN,              // amplifier 2 at supply
  input  wire logic                   AMP2_SAT_LOW_IN,               // amplifier 2 at ground
  input  wire logic                   AMP3_CM_VIOLATION_IN,          // stage 3 common-mode fault
  input  wire logic                   EXC_REF_LOWER_IN,              // excitation ref below supply ref
  input  wire logic                   EXCITATION_ENABLE_IN,          // bridge_excitation enabled
  input  wire logic                   VOUT_ENABLE_IN,                // analog output enabled
  input  wire logic [`SFM_ADDR_W-1:0] REG_ADDR_IN,                   // register index from serial front end
  input  wire logic                   REG_WR_IN,                     // write strobe, one cycle
  input  wire logic [`SFM_DATA_W-1:0] REG_WDATA_IN,                  // write data
  output logic      [`SFM_DATA_W-1:0] REG_RDATA_OUT,                 // read data of REG_ADDR_IN
  output logic      [`SFM_DATA_W-1:0] ALARM_STATUS_OUT,              // alarm status register
  output logic                        FAULT_FORCE_OUT,               // override linear output
  output logic                        FAULT_LEVEL_HIGH_OUT,          // forced level: 1 supply, 0 ground
  output logic                        THRESH_SEL_EXC_OUT             // use excitation-minus-100 mV ref
);
  import sfm_pkg::*;

  // ==========================================================
  // synchronisation of analog comparator levels
  logic [`SFM_CMP_W-1:0] raw_cmp;
  logic [`SFM_CMP_W-1:0] live;
  logic                  ext_flag;
  logic                  ext_active;
  logic                  int_flag;
  logic                  int_active;
  sfm_state_t            st_reg;
  sfm_state_t            st_next;

  assign raw_cmp = {EXC_REF_LOWER_IN,
                    AMP3_CM_VIOLATION_IN,
                    AMP2_SAT_LOW_IN, AMP2_SAT_HIGH_IN,
                    AMP1_SAT_LOW_IN, AMP1_SAT_HIGH_IN,
                    NEG_INPUT_HIGH_COMPARATOR_IN, NEG_INPUT_LOW_COMPARATOR_IN,
                    POS_INPUT_HIGH_COMPARATOR_IN, POS_INPUT_LOW_COMPARATOR_IN};

  sfm_sync2 u_sync (
    .clk_in   (CLK_IN),
    .rstn_in  (RSTN_IN),
    .async_in (raw_cmp),
    .sync_out (live)
  );

  // ==========================================================
  // group flags
  sfm_group #(.W(`SFM_EXT_W)) u_ext_group (
    .cmp_in     (live[`SFM_EXT_LSB +: `SFM_EXT_W]),
    .enable_in  (st_reg.cfg[`SFM_CFG_EXT_EN]),
    .flag_out   (ext_flag),
    .active_out (ext_active)
  );

  sfm_group #(.W(`SFM_INT_W)) u_int_group (
    .cmp_in     (live[`SFM_INT_LSB +: `SFM_INT_W]),
    .enable_in  (st_reg.cfg[`SFM_CFG_INT_EN]),
    .flag_out   (int_flag),
    .active_out (int_active)
  );

  // ==========================================================
  // next state
  always_comb begin
    st_next = st_reg;
    if (REG_WR_IN && (REG_ADDR_IN == `SFM_IDX_FAULT_CFG)) begin
      st_next.cfg = REG_WDATA_IN;
    end
    // frozen while output is off, so a shared pin keeps the last picture
    if (VOUT_ENABLE_IN) begin
      st_next.alarm                  = `SFM_ZERO_DATA;
      st_next.alarm[`SFM_ALM_W-1:0]  = live[`SFM_ALM_W-1:0];
    end
    // read data of the current index; writes and reads are independent
    unique case (REG_ADDR_IN)
      `SFM_IDX_FAULT_CFG: st_next.rd_data = st_reg.cfg;
      `SFM_IDX_ALARM:     st_next.rd_data = st_reg.alarm;
      default:            st_next.rd_data = `SFM_ZERO_DATA;
    endcase
    st_next.force_on   = ext_active | int_active;
    // external level has priority over the internal one
    st_next.level_high = ext_active ? st_reg.cfg[`SFM_CFG_EXT_POL]
                                    : st_reg.cfg[`SFM_CFG_INT_POL];
    // minimum selector: pick excitation ref only when it is lower
    st_next.thresh_exc = EXCITATION_ENABLE_IN & live[`SFM_EXC_BIT];
  end

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      st_reg.cfg        <= `SFM_FAULT_CFG_RST;
      st_reg.alarm      <= `SFM_ZERO_DATA;
      st_reg.rd_data    <= `SFM_ZERO_DATA;
      st_reg.force_on   <= 1'b0;
      st_reg.level_high <= 1'b0;
      st_reg.thresh_exc <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign REG_RDATA_OUT        = st_reg.rd_data;
  assign ALARM_STATUS_OUT     = st_reg.alarm;
  assign FAULT_FORCE_OUT      = st_reg.force_on;
  assign FAULT_LEVEL_HIGH_OUT = st_reg.level_high;
  assign THRESH_SEL_EXC_OUT   = st_reg.thresh_exc;

  // ==========================================================
  // assertions
  // helper: cycles since reset release, saturating at 3
  logic [1:0] up_cnt;
  logic       ext_en_c;
  logic       int_en_c;
  logic       cfg_hit_c;

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      up_cnt <= 2'h0;
    end else if (up_cnt != 2'h3) begin
      up_cnt <= up_cnt + 2'h1;
    end
  end

  assign ext_en_c = st_reg.cfg[`SFM_CFG_EXT_EN];
  assign int_en_c = st_reg.cfg[`SFM_CFG_INT_EN];
  assign cfg_hit_c = REG_WR_IN && (REG_ADDR_IN == `SFM_IDX_FAULT_CFG);

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);

  alarm_follow_a: assert property ((up_cnt == 2'h3) && VOUT_ENABLE_IN |=>
    ALARM_STATUS_OUT[3:0] == $past({NEG_INPUT_HIGH_COMPARATOR_IN, NEG_INPUT_LOW_COMPARATOR_IN,
                                    POS_INPUT_HIGH_COMPARATOR_IN, POS_INPUT_LOW_COMPARATOR_IN}, 3))
    else $error("alarm bits 3:0 do not track external comparators");

  internal_alarm_a: assert property ((up_cnt == 2'h3) && VOUT_ENABLE_IN |=>
    ALARM_STATUS_OUT[8:4] == $past({AMP3_CM_VIOLATION_IN, AMP2_SAT_LOW_IN, AMP2_SAT_HIGH_IN,
                                    AMP1_SAT_LOW_IN, AMP1_SAT_HIGH_IN}, 3) &&
    ALARM_STATUS_OUT[15:9] == 7'h00)
    else $error("alarm bits 8:4 do not track internal comparators");

  alarm_freeze_a: assert property (!VOUT_ENABLE_IN [*2] |=> $stable(ALARM_STATUS_OUT))
    else $error("alarm status changed while output disabled");

  status_read_a: assert property ((REG_ADDR_IN == `SFM_IDX_ALARM) |=>
    REG_RDATA_OUT == $past(ALARM_STATUS_OUT))
    else $error("alarm status read wrong");

  cfg_readback_a: assert property (REG_WR_IN && (REG_ADDR_IN == `SFM_IDX_FAULT_CFG) ##1
    (REG_ADDR_IN == `SFM_IDX_FAULT_CFG) |=> REG_RDATA_OUT == $past(REG_WDATA_IN, 2))
    else $error("config register readback wrong");

  ext_force_a: assert property (ext_flag && ext_en_c |=>
    FAULT_FORCE_OUT && FAULT_LEVEL_HIGH_OUT == $past(st_reg.cfg[`SFM_CFG_EXT_POL]))
    else $error("external fault did not force its level");

  int_force_a: assert property (int_flag && int_en_c && !(ext_flag && ext_en_c) |=>
    FAULT_FORCE_OUT && FAULT_LEVEL_HIGH_OUT == $past(st_reg.cfg[`SFM_CFG_INT_POL]))
    else $error("internal fault did not force its level");

  no_force_a: assert property (!(ext_flag && ext_en_c) && !(int_flag && int_en_c) |=>
    !FAULT_FORCE_OUT)
    else $error("output forced without enabled fault");

  // judged against the pins, two synchroniser stages back
  any_high_a: assert property ((up_cnt == 2'h3) |->
    ext_flag == ($past({NEG_INPUT_HIGH_COMPARATOR_IN, NEG_INPUT_LOW_COMPARATOR_IN,
                        POS_INPUT_HIGH_COMPARATOR_IN, POS_INPUT_LOW_COMPARATOR_IN}, 2) != 4'h0) &&
    int_flag == ($past({AMP3_CM_VIOLATION_IN, AMP2_SAT_LOW_IN, AMP2_SAT_HIGH_IN,
                        AMP1_SAT_LOW_IN, AMP1_SAT_HIGH_IN}, 2) != 5'h00))
    else $error("group flag not the OR of its comparators");

  thresh_sel_a: assert property ((EXCITATION_ENABLE_IN && EXC_REF_LOWER_IN) [*3] |=>
    THRESH_SEL_EXC_OUT)
    else $error("lower excitation reference not selected");

  thresh_off_a: assert property (!EXCITATION_ENABLE_IN |=> !THRESH_SEL_EXC_OUT)
    else $error("excitation reference used with excitation off");

  // excitation enable is same-clock, the reference decision crosses two stages
  thresh_pin_a: assert property ((up_cnt == 2'h3) && EXCITATION_ENABLE_IN |=>
    THRESH_SEL_EXC_OUT == $past(EXC_REF_LOWER_IN, 3))
    else $error("threshold select does not follow the reference decision");

  // ==========================================================
  // register port checks
  reset_clear_a: assert property (disable iff (1'b0) !RSTN_IN |=>
    st_reg.cfg == `SFM_FAULT_CFG_RST && REG_RDATA_OUT == `SFM_ZERO_DATA &&
    ALARM_STATUS_OUT == `SFM_ZERO_DATA && !FAULT_FORCE_OUT && !FAULT_LEVEL_HIGH_OUT &&
    !THRESH_SEL_EXC_OUT)
    else $error("outputs not cleared by reset");

  cfg_write_a: assert property (cfg_hit_c |=>
    st_reg.cfg == $past(REG_WDATA_IN))
    else $error("config write did not land");

  cfg_hold_a: assert property (!cfg_hit_c |=> $stable(st_reg.cfg))
    else $error("config changed without a write to its index");

  cfg_read_a: assert property ((REG_ADDR_IN == `SFM_IDX_FAULT_CFG) |=>
    REG_RDATA_OUT == $past(st_reg.cfg))
    else $error("config read data wrong");

  unmapped_read_a: assert property ((REG_ADDR_IN != `SFM_IDX_FAULT_CFG) &&
    (REG_ADDR_IN != `SFM_IDX_ALARM) |=> REG_RDATA_OUT == `SFM_ZERO_DATA)
    else $error("unmapped index did not read zero");

  alarm_ro_a: assert property (!VOUT_ENABLE_IN && REG_WR_IN &&
    (REG_ADDR_IN == `SFM_IDX_ALARM) |=> $stable(ALARM_STATUS_OUT))
    else $error("write reached the read-only alarm status");

  alarm_upper_a: assert property (ALARM_STATUS_OUT[15:9] == 7'h00)
    else $error("unused alarm bits not zero");

  // per-bit view: a swapped or stuck bit names itself
  for (genvar b = 0; b < `SFM_ALM_W; b++) begin : g_alarm_bit
    alarm_bit_a: assert property ((up_cnt == 2'h3) && VOUT_ENABLE_IN |=>
      ALARM_STATUS_OUT[b] == $past(raw_cmp[b], 3))
      else $error("single alarm bit does not track its comparator");
  end

  // ==========================================================
  // fault forcing checks: force judged from the pins, priority and idle level from the group gates
  ext_pin_force_a: assert property ((up_cnt == 2'h3) && ext_en_c &&
    ($past({NEG_INPUT_HIGH_COMPARATOR_IN, NEG_INPUT_LOW_COMPARATOR_IN,
            POS_INPUT_HIGH_COMPARATOR_IN, POS_INPUT_LOW_COMPARATOR_IN}, 2) != 4'h0) |=>
    FAULT_FORCE_OUT && FAULT_LEVEL_HIGH_OUT == $past(st_reg.cfg[`SFM_CFG_EXT_POL]))
    else $error("external comparator high did not force the output");

  int_pin_force_a: assert property ((up_cnt == 2'h3) && int_en_c && !ext_active &&
    ($past({AMP3_CM_VIOLATION_IN, AMP2_SAT_LOW_IN, AMP2_SAT_HIGH_IN,
            AMP1_SAT_LOW_IN, AMP1_SAT_HIGH_IN}, 2) != 5'h00) |=>
    FAULT_FORCE_OUT && FAULT_LEVEL_HIGH_OUT == $past(st_reg.cfg[`SFM_CFG_INT_POL]))
    else $error("internal comparator high did not force the output");

  ext_priority_a: assert property (ext_active && int_active |=>
    FAULT_LEVEL_HIGH_OUT == $past(st_reg.cfg[`SFM_CFG_EXT_POL]))
    else $error("internal polarity won over external");

  level_idle_a: assert property (!ext_active |=>
    FAULT_LEVEL_HIGH_OUT == $past(st_reg.cfg[`SFM_CFG_INT_POL]))
    else $error("level not internal polarity without external force");

  cover_ext_force_c:  cover property (ext_flag && ext_en_c ##1 FAULT_FORCE_OUT);
  cover_both_fault_c: cover property (ext_active && int_active &&
    (st_reg.cfg[`SFM_CFG_EXT_POL] != st_reg.cfg[`SFM_CFG_INT_POL]));
  cover_int_force_c:  cover property (int_active && !ext_flag ##1 FAULT_FORCE_OUT);
  cover_freeze_c:     cover property (VOUT_ENABLE_IN ##1 !VOUT_ENABLE_IN [*3]);
  cover_thresh_c:     cover property (EXCITATION_ENABLE_IN && EXC_REF_LOWER_IN ##3 THRESH_SEL_EXC_OUT);

endmodule : sfm_monitor

/* testbench/sfm_sensor_model.sv */
// comparator front of the bridge sensor and the front-end amplifiers
`timescale 1ns/10ps

module sfm_sensor_model (
  input  wire logic [8:0] fault_in,     // fault pattern in alarm layout
  input  wire logic       exc_low_in,   // excitation reference is the lower one
  output logic      [3:0] ext_out,      // pos lo, pos hi, neg lo, neg hi
  output logic      [4:0] int_out,      // a1 hi, a1 lo, a2 hi, a2 lo, a3 cm
  output logic            exc_lower_out // min-selector decision
);
  // ==========================================================
  // comparator levels
  // analog comparators settle instantly here; real ones chatter near the trip point
  assign ext_out       = fault_in[3:0];
  assign int_out       = fault_in[8:4];
  assign exc_lower_out = exc_low_in;
endmodule : sfm_sensor_model

/* testbench/testbench.sv */
// self-checking testbench of the sensor fault monitor logic
`timescale 1ns/10ps
`include "sfm_cfg.svh"

module testbench;
  logic        clk_in  = 1'b0;
  logic        rstn_in = 1'b0;
  logic [8:0]  fault   = 9'h000;
  logic        exc_low = 1'b0;
  logic        exc_en  = 1'b0;
  logic        vout_en = 1'b0;
  logic        wr      = 1'b0;
  logic [7:0]  addr    = 8'h00;
  logic [15:0] wdata   = 16'h0000;
  logic [3:0]  ext;
  logic [4:0]  intc;
  logic        exc_lower;
  logic [15:0] rdata;
  logic [15:0] alarm;
  logic        force_o;
  logic        lvl;
  logic        thr;
  int          num_errors  = 0;
  int          check_count = 0;

  always #50 clk_in = ~clk_in;

  sfm_sensor_model sensor (.fault_in(fault), .exc_low_in(exc_low), .ext_out(ext), .int_out(intc),
                           .exc_lower_out(exc_lower));
  sfm_monitor dut (.CLK_IN(clk_in), .RSTN_IN(rstn_in), .POS_INPUT_HIGH_COMPARATOR_IN(ext[1]),
    .POS_INPUT_LOW_COMPARATOR_IN(ext[0]), .NEG_INPUT_HIGH_COMPARATOR_IN(ext[3]),
    .NEG_INPUT_LOW_COMPARATOR_IN(ext[2]), .AMP1_SAT_HIGH_IN(intc[0]), .AMP1_SAT_LOW_IN(intc[1]),
    .AMP2_SAT_HIGH_IN(intc[2]), .AMP2_SAT_LOW_IN(intc[3]), .AMP3_CM_VIOLATION_IN(intc[4]),
    .EXC_REF_LOWER_IN(exc_lower), .EXCITATION_ENABLE_IN(exc_en), .VOUT_ENABLE_IN(vout_en),
    .REG_ADDR_IN(addr), .REG_WR_IN(wr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
    .ALARM_STATUS_OUT(alarm), .FAULT_FORCE_OUT(force_o), .FAULT_LEVEL_HIGH_OUT(lvl),
    .THRESH_SEL_EXC_OUT(thr));

  // ==========================================================
  // compare and bus tasks
  task automatic check16(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check16

  task automatic check1(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask : check1

  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_in);
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    @(negedge clk_in);
    wr    = 1'b0;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, input logic [15:0] exp, input string name);
    @(negedge clk_in);
    addr = a;
    @(negedge clk_in);
    check16(name, exp, rdata);
  endtask : read_reg

  // two synchroniser stages plus the output register, with margin
  task automatic settle();
    repeat (4) @(negedge clk_in);
  endtask : settle

  // ==========================================================
  // scenarios
  task automatic test_regs();
    check1("force after reset", 1'b0, force_o);
    read_reg(8'h05, 16'h0000, "config after reset");
    write_reg(8'h05, 16'ha5c3);
    read_reg(8'h05, 16'ha5c3, "config readback");
    write_reg(8'h08, 16'hffff);
    read_reg(8'h08, 16'h0000, "alarm is read-only");
    write_reg(8'h06, 16'h1234);
    read_reg(8'h05, 16'ha5c3, "config after stray write");
    read_reg(8'h07, 16'h0000, "unmapped index");
    $display("test_regs done");
  endtask : test_regs

  task automatic test_alarm();
    vout_en = 1'b1;
    for (int i = 0; i < 9; i++) begin
      fault = 9'h001 << i;
      settle();
      check16("alarm bit", {7'h00, fault}, alarm);
      read_reg(8'h08, {7'h00, fault}, "alarm over bus");
    end
    $display("test_alarm done");
  endtask : test_alarm

  task automatic test_freeze();
    fault = 9'h005;
    settle();
    vout_en = 1'b0;
    fault   = 9'h1a0;
    settle();
    check16("frozen alarm", 16'h0005, alarm);
    read_reg(8'h08, 16'h0005, "frozen alarm over bus");
    vout_en = 1'b1;
    settle();
    check16("alarm after enable", 16'h01a0, alarm);
    $display("test_freeze done");
  endtask : test_freeze

  task automatic test_force();
    // cfg bits 11:8 (ext en, int en, ext pol, int pol), fault pattern, force, level
    logic [14:0] cases [9];
    cases = '{{4'ha, 9'h001, 2'b11}, {4'h2, 9'h001, 2'b00}, {4'h4, 9'h010, 2'b10},
              {4'h1, 9'h010, 2'b00}, {4'he, 9'h011, 2'b11}, {4'hd, 9'h011, 2'b10},
              {4'hd, 9'h010, 2'b11}, {4'hf, 9'h000, 2'b00}, {4'h8, 9'h00c, 2'b10}};
    for (int i = 0; i < 9; i++) begin
      write_reg(8'h05, {4'h0, cases[i][14:11], 8'h00});
      fault = cases[i][10:2];
      settle();
      check1("fault force", cases[i][1], force_o);
      if (cases[i][1]) begin
        check1("fault level", cases[i][0], lvl);
      end
    end
    $display("test_force done");
  endtask : test_force

  task automatic test_thresh();
    fault = 9'h000;
    for (int i = 0; i < 4; i++) begin
      exc_en  = i[1];
      exc_low = i[0];
      settle();
      check1("threshold select", i[1] & i[0], thr);
    end
    $display("test_thresh done");
  endtask : test_thresh

  // ==========================================================
  // verdict
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // whole sequence needs under two hundred cycles
  initial begin
    repeat (3000) @(posedge clk_in);
    num_errors++;
    tally_and_finish();
  end

  initial begin
    repeat (10) @(negedge clk_in);
    rstn_in = 1'b1;
    test_regs();
    test_alarm();
    test_freeze();
    test_force();
    test_thresh();
    tally_and_finish();
  end
endmodule : testbench
